// ### fmp_pkg.sv
// Register map, field layout, timing constants and carrier types of the float-mode pulse controller.
package fmp_pkg;

    // Clock and timing base.
    localparam int CLK_PERIOD_NS   = 20;
    localparam int NS_PER_US       = 1000;
    localparam int PULSE_STEP_US   = 1;
    localparam int PRECON_STEP_NS  = 2000;
    localparam int GAP_US          = 1;
    localparam int PULSE_STEP_CYC  = (PULSE_STEP_US * NS_PER_US) / CLK_PERIOD_NS;
    localparam int PRECON_STEP_CYC = PRECON_STEP_NS / CLK_PERIOD_NS;
    localparam int GAP_CYC         = (GAP_US * NS_PER_US) / CLK_PERIOD_NS;

    // Interval counter width; 31 preconditioning steps need 3100 cycles.
    localparam int                CNT_W   = 12;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    // Serial frame: 7 address bits, one write flag, 16 data bits.
    localparam int         ADDR_BITS      = 7;
    localparam int         DATA_BITS      = 16;
    localparam logic [4:0] CMD_LAST_BIT   = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT = 5'h17;

    // Register offsets.
    localparam logic [ADDR_BITS-1:0] ADDR_SIGN  = 7'h58;
    localparam logic [ADDR_BITS-1:0] ADDR_EN_B  = 7'h59;
    localparam logic [ADDR_BITS-1:0] ADDR_FIRE  = 7'h5a;
    localparam logic [ADDR_BITS-1:0] ADDR_EN_A  = 7'h5e;

    // Reset values.
    localparam logic [DATA_BITS-1:0] RST_SIGN   = 16'h0000;
    localparam logic [DATA_BITS-1:0] RST_EN     = 16'h0808;
    localparam logic [DATA_BITS-1:0] RST_FIRE   = 16'h0010;

    // Field positions.
    localparam int EN_MSB       = 14;
    localparam int EN_LSB       = 13;
    localparam int PRECON_MSB   = 12;
    localparam int PRECON_LSB   = 8;
    localparam int FIRE_A_LSB   = 8;
    localparam int FIRE_B_LSB   = 12;
    localparam int SIGN12_A_LSB = 1;
    localparam int SIGN12_B_LSB = 5;
    localparam int SIGN34_A_LSB = 8;
    localparam int SIGN34_B_LSB = 10;

    // Float enable codes; 1 and 2 are reserved and act as disabled.
    localparam logic [1:0] FLOAT_OFF = 2'h0;
    localparam logic [1:0] FLOAT_ON  = 2'h3;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_PRECON, SEQ_PULSE, SEQ_GAP} fmp_seq_state_t;

    // Per-slot settings taken from the register bank, with the width taken from the pulseWidth input.
    typedef struct packed {
        logic [1:0] enable;
        logic [4:0] precon;
        logic [3:0] fireMask;
        logic [1:0] sign12;
        logic [1:0] sign34;
        logic [4:0] width;
    } fmp_slot_cfg_t;

    // Per-slot sequence outputs.
    typedef struct packed {
        logic       ledOn;
        logic       sampleStrobe;
        logic       sampleSubtract;
        logic [1:0] pulsePos;
        logic       busy;
    } fmp_seq_out_t;

endpackage

// ### fmp_interval_timer.sv
// Loadable down-counter that times one phase of a slot sequence.
`timescale 1ns/1ps
module fmp_interval_timer
    import fmp_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rstN,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] loadValue,
    output logic                  done
);
    logic [CNT_W-1:0] cnt_q;

    // Done marks the last cycle of a phase loaded with the same value.
    assign done = (cnt_q == CNT_ONE);

    // The counter parks at zero so an unloaded timer never reports done.
    always_ff @(posedge mclk or negedge rstN)
    begin
        if (!rstN)
            cnt_q <= '0;
        else if (load)
            cnt_q <= loadValue;
        else if (cnt_q != '0)
            cnt_q <= CNT_W'(cnt_q - CNT_ONE);
    end
endmodule

// ### fmp_spi_port.sv
// Serial configuration port: synchronises the pins and turns frames into register reads and writes.
`timescale 1ns/1ps
module fmp_spi_port
    import fmp_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rstN,
    input  wire logic                 sclkPin,
    input  wire logic                 csPinN,
    input  wire logic                 mosiPin,
    output logic                      miso,
    output logic                      misoOe,
    output logic [ADDR_BITS-1:0]      regAddr,
    output logic                      regWrite,
    output logic [DATA_BITS-1:0]      regWdata,
    input  wire logic [DATA_BITS-1:0] regRdata
);
    logic [2:0]           pinMeta_q;
    logic [2:0]           pinSync_q;
    logic                 sclkPrev_q;
    logic [4:0]           bitCnt_q;
    logic [DATA_BITS-1:0] shiftIn_q;
    logic [DATA_BITS-1:0] shiftOut_q;
    logic                 isWrite_q;
    logic                 loadRd_q;

    // Edges are found on the second synchroniser stage only.
    wire sclkSync  = pinSync_q[2];
    wire csActive  = !pinSync_q[1];
    wire mosiSync  = pinSync_q[0];
    wire sclkRise  = csActive && sclkSync && !sclkPrev_q;
    wire sclkFall  = csActive && !sclkSync && sclkPrev_q;
    wire cmdDone   = sclkRise && (bitCnt_q == CMD_LAST_BIT);
    wire dataDone  = sclkRise && (bitCnt_q == FRAME_LAST_BIT) && isWrite_q;
    wire readPhase = csActive && !isWrite_q && (bitCnt_q > CMD_LAST_BIT);

    // Read data is fetched one cycle after the command byte, long before the next falling edge.
    always_ff @(posedge mclk or negedge rstN)
    begin
        if (!rstN)
        begin
            pinMeta_q  <= 3'h2;
            pinSync_q  <= 3'h2;
            sclkPrev_q <= 1'h0;
            bitCnt_q   <= '0;
            shiftIn_q  <= '0;
            shiftOut_q <= '0;
            isWrite_q  <= 1'h0;
            loadRd_q   <= 1'h0;
            regAddr    <= '0;
            regWrite   <= 1'h0;
            regWdata   <= '0;
            miso       <= 1'h0;
            misoOe     <= 1'h0;
        end
        else
        begin
            pinMeta_q  <= {sclkPin, csPinN, mosiPin};
            pinSync_q  <= pinMeta_q;
            sclkPrev_q <= sclkSync;
            loadRd_q   <= cmdDone && !mosiSync;
            regWrite   <= dataDone;
            misoOe     <= readPhase;
            if (!csActive)
                bitCnt_q <= '0;
            else if (sclkRise)
            begin
                bitCnt_q  <= 5'(bitCnt_q + 5'h01);
                shiftIn_q <= {shiftIn_q[DATA_BITS-2:0], mosiSync};
            end
            if (cmdDone)
            begin
                regAddr   <= shiftIn_q[ADDR_BITS-1:0];
                isWrite_q <= mosiSync;
            end
            if (dataDone)
                regWdata <= {shiftIn_q[DATA_BITS-2:0], mosiSync};
            if (loadRd_q)
                shiftOut_q <= regRdata;
            else if (sclkFall && readPhase)
            begin
                miso       <= shiftOut_q[DATA_BITS-1];
                shiftOut_q <= {shiftOut_q[DATA_BITS-2:0], 1'h0};
            end
        end
    end
endmodule

// ### fmp_float_control.sv
// Float-mode register bank and per-slot pulse sequencers with serial register access.
//
// Overview of operation
// - Slot A sample 1/2 sign code 00 adds both, 01 subtracts the second, 10 the first, 11 both.
// - The slot A sample 1/2 sign code repeats for every group of four pulses in a longer sequence.
// - Slot B float enable code 3 turns float mode on, 0 turns it off, and 1 or 2 are reserved.
// - Slot A float enable code 3 turns float mode on, 0 turns it off, and it resets to 0.
// - Slot B has a 5-bit preconditioning delay before the first float interval, reset to 0x08.
// - Slot A has a 5-bit preconditioning delay before the first float interval, reset to 0x08.
// - Slot B fire-mask bits 12 to 15 map to pulses one to four of a group, 0 fires and 1 masks.
// - Slot A fire-mask bits 8 to 11 map to pulses one to four of a group, 0 fires and 1 masks.
// - Each slot's sample 3/4 sign code selects add or subtract for the third and fourth samples.
// - Each slot's float pulse width counts in steps of one microsecond.
`timescale 1ns/1ps
module fmp_float_control
    import fmp_pkg::*;
#(
    parameter int COUNT_W = 8
)
(
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic               spiSclk,
    input  wire logic               spiCsN,
    input  wire logic               spiMosi,
    output logic                    spiMiso,
    output logic                    spiMisoOe,
    input  wire logic [1:0]         slotStart,
    input  wire logic [COUNT_W-1:0] pulseCount [2],
    input  wire logic [4:0]         pulseWidth [2],
    output fmp_seq_out_t            seqOut [2]
);
    logic                 rstMeta_q;
    logic                 rstSyncN;
    logic [ADDR_BITS-1:0] regAddr;
    logic                 regWrite;
    logic [DATA_BITS-1:0] regWdata;
    logic [DATA_BITS-1:0] regRdata;
    logic [DATA_BITS-1:0] regSign_q;
    logic [DATA_BITS-1:0] regEnA_q;
    logic [DATA_BITS-1:0] regEnB_q;
    logic [DATA_BITS-1:0] regFire_q;
    logic [3:0]           fireSeenA_q;
    logic [3:0]           fireSeenB_q;
    fmp_slot_cfg_t        slotCfg [2];

    // Reset is asserted at once and released through two flops to avoid a ragged release.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta_q <= 1'h0;
            rstSyncN  <= 1'h0;
        end
        else
        begin
            rstMeta_q <= 1'h1;
            rstSyncN  <= rstMeta_q;
        end
    end

    fmp_spi_port u_port (
        .mclk     (mclk),
        .rstN     (rstSyncN),
        .sclkPin  (spiSclk),
        .csPinN   (spiCsN),
        .mosiPin  (spiMosi),
        .miso     (spiMiso),
        .misoOe   (spiMisoOe),
        .regAddr  (regAddr),
        .regWrite (regWrite),
        .regWdata (regWdata),
        .regRdata (regRdata)
    );

    // Address decode; every bit of a mapped register reads back, unmapped offsets read zero.
    wire hitSign = (regAddr == ADDR_SIGN);
    wire hitEnB  = (regAddr == ADDR_EN_B);
    wire hitFire = (regAddr == ADDR_FIRE);
    wire hitEnA  = (regAddr == ADDR_EN_A);
    assign regRdata = hitSign ? regSign_q :
                      hitEnB  ? regEnB_q  :
                      hitFire ? regFire_q :
                      hitEnA  ? regEnA_q  : '0;

    // Register storage; reserved bits keep what software writes, which it keeps at their defaults.
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            regSign_q <= RST_SIGN;
            regEnA_q  <= RST_EN;
            regEnB_q  <= RST_EN;
            regFire_q <= RST_FIRE;
        end
        else if (regWrite)
        begin
            if (hitSign)
                regSign_q <= regWdata;
            if (hitEnA)
                regEnA_q <= regWdata;
            if (hitEnB)
                regEnB_q <= regWdata;
            if (hitFire)
                regFire_q <= regWdata;
        end
    end

    // Field extraction into the per-slot settings, slot A at index 0 and slot B at index 1.
    assign slotCfg[0] = {regEnA_q[EN_MSB:EN_LSB],
                         regEnA_q[PRECON_MSB:PRECON_LSB],
                         regFire_q[FIRE_A_LSB +: 4],
                         regSign_q[SIGN12_A_LSB +: 2],
                         regSign_q[SIGN34_A_LSB +: 2],
                         pulseWidth[0]};
    assign slotCfg[1] = {regEnB_q[EN_MSB:EN_LSB],
                         regEnB_q[PRECON_MSB:PRECON_LSB],
                         regFire_q[FIRE_B_LSB +: 4],
                         regSign_q[SIGN12_B_LSB +: 2],
                         regSign_q[SIGN34_B_LSB +: 2],
                         pulseWidth[1]};

    // One sequencer per slot; both slots share the same timing and sign behaviour.
    for (genvar s = 0; s < 2; s++)
    begin : g_slot
        fmp_seq_state_t     state_q;
        fmp_seq_state_t     state_d;
        logic [COUNT_W-1:0] idx_q;
        logic [COUNT_W-1:0] idx_d;
        fmp_seq_out_t       out_d;
        logic               timerLoad;
        logic [CNT_W-1:0]   timerValue;
        logic               timerDone;
        logic [3:0]         signSeen_q;
        logic [1:0]         enSeen_q;
        logic [1:0]         strobeCnt_q;
        logic [CNT_W-1:0]   phaseCyc_q;

        // Only code 3 enables; the reserved codes behave as off.
        wire floatOn = (slotCfg[s].enable == FLOAT_ON);
        wire [CNT_W-1:0] preconLoad = (slotCfg[s].precon == '0) ? CNT_ONE :
                                      CNT_W'(slotCfg[s].precon * PRECON_STEP_CYC);
        wire [CNT_W-1:0] widthLoad = (slotCfg[s].width == '0) ? CNT_ONE :
                                     CNT_W'(slotCfg[s].width * PULSE_STEP_CYC);
        wire [CNT_W-1:0] gapLoad = CNT_W'(GAP_CYC);
        wire lastPulse = (COUNT_W'(idx_q + 1'h1) == pulseCount[s]);
        // Pulse position wraps every four pulses, so sign and mask repeat per group.
        wire [1:0] groupPos = idx_d[1:0];
        // Subtract flags by position: sample 1, 2 from the first code, 3, 4 from the second.
        wire [3:0] subtractAt = {slotCfg[s].sign34[0], slotCfg[s].sign34[1],
                                 slotCfg[s].sign12[0], slotCfg[s].sign12[1]};

        fmp_interval_timer u_timer (
            .mclk      (mclk),
            .rstN      (rstSyncN),
            .load      (timerLoad),
            .loadValue (timerValue),
            .done      (timerDone)
        );

        // Sequence: preconditioning delay, then pulse and gap phases for each pulse.
        always_comb
        begin
            state_d    = state_q;
            idx_d      = idx_q;
            timerLoad  = 1'h0;
            timerValue = widthLoad;
            case (state_q)
                SEQ_IDLE:
                    if (slotStart[s] && floatOn && pulseCount[s] != '0)
                    begin
                        state_d    = SEQ_PRECON;
                        idx_d      = '0;
                        timerLoad  = 1'h1;
                        timerValue = preconLoad;
                    end
                SEQ_PRECON:
                    if (timerDone)
                    begin
                        state_d   = SEQ_PULSE;
                        timerLoad = 1'h1;
                    end
                SEQ_PULSE:
                    if (timerDone)
                    begin
                        state_d    = SEQ_GAP;
                        timerLoad  = 1'h1;
                        timerValue = gapLoad;
                    end
                SEQ_GAP:
                    if (timerDone)
                    begin
                        if (lastPulse)
                            state_d = SEQ_IDLE;
                        else
                        begin
                            state_d   = SEQ_PULSE;
                            idx_d     = COUNT_W'(idx_q + 1'h1);
                            timerLoad = 1'h1;
                        end
                    end
                default:
                    state_d = SEQ_IDLE;
            endcase
            // Clearing the enable abandons a running sequence at once.
            if (!floatOn)
                state_d = SEQ_IDLE;
        end

        // Output image of the next state, so every output comes from a flop.
        assign out_d.ledOn          = (state_d == SEQ_PULSE) && !slotCfg[s].fireMask[groupPos];
        assign out_d.sampleStrobe   = (state_q == SEQ_PULSE) && (state_d == SEQ_GAP);
        assign out_d.sampleSubtract = subtractAt[groupPos];
        assign out_d.pulsePos       = groupPos;
        assign out_d.busy           = (state_d != SEQ_IDLE);

        always_ff @(posedge mclk or negedge rstSyncN)
        begin
            if (!rstSyncN)
            begin
                state_q   <= SEQ_IDLE;
                idx_q     <= '0;
                seqOut[s] <= '0;
            end
            else
            begin
                state_q   <= state_d;
                idx_q     <= idx_d;
                seqOut[s] <= out_d;
            end
        end

        // Checking aids: delayed settings, strobe count since start, cycles spent in a phase.
        always_ff @(posedge mclk or negedge rstSyncN)
        begin
            if (!rstSyncN)
            begin
                signSeen_q  <= '0;
                enSeen_q    <= FLOAT_OFF;
                strobeCnt_q <= '0;
                phaseCyc_q  <= '0;
            end
            else
            begin
                signSeen_q  <= {slotCfg[s].sign34, slotCfg[s].sign12};
                enSeen_q    <= slotCfg[s].enable;
                phaseCyc_q  <= (state_d != state_q) ? '0 : CNT_W'(phaseCyc_q + CNT_ONE);
                if (state_q == SEQ_IDLE && state_d == SEQ_PRECON)
                    strobeCnt_q <= '0;
                else if (seqOut[s].sampleStrobe)
                    strobeCnt_q <= 2'(strobeCnt_q + 2'h1);
            end
        end

        a_sign_pair12: assert property (@(posedge mclk) disable iff (!rstSyncN)
            seqOut[s].sampleStrobe && !seqOut[s].pulsePos[1]
                |-> seqOut[s].sampleSubtract == signSeen_q[{1'b0, !seqOut[s].pulsePos[0]}])
            else $error("Sample 1/2 sign does not follow its code.");
        a_sign_pair34: assert property (@(posedge mclk) disable iff (!rstSyncN)
            seqOut[s].sampleStrobe && seqOut[s].pulsePos[1]
                |-> seqOut[s].sampleSubtract == signSeen_q[{1'b1, !seqOut[s].pulsePos[0]}])
            else $error("Sample 3/4 sign does not follow its code.");
        a_group_wrap_pos: assert property (@(posedge mclk) disable iff (!rstSyncN)
            seqOut[s].sampleStrobe |-> seqOut[s].pulsePos == strobeCnt_q)
            else $error("Pulse position does not wrap every four samples.");
        a_precon_time: assert property (@(posedge mclk) disable iff (!rstSyncN)
            state_q == SEQ_PRECON && state_d == SEQ_PULSE |-> CNT_W'(phaseCyc_q + CNT_ONE) == preconLoad)
            else $error("Preconditioning delay has the wrong length.");
        a_pulse_width: assert property (@(posedge mclk) disable iff (!rstSyncN)
            state_q == SEQ_PULSE && state_d == SEQ_GAP |-> CNT_W'(phaseCyc_q + CNT_ONE) == widthLoad)
            else $error("LED pulse has the wrong width.");
        a_disabled_idle: assert property (@(posedge mclk) disable iff (!rstSyncN)
            !floatOn |=> !seqOut[s].busy && !seqOut[s].ledOn ##1 !seqOut[s].sampleStrobe || floatOn)
            else $error("Disabled slot still sequences.");
        a_enable_code: assert property (@(posedge mclk) disable iff (!rstSyncN)
            $rose(seqOut[s].busy) |-> enSeen_q == FLOAT_ON && $past(slotStart[s]))
            else $error("Sequence started without enable code 3.");
    end

    // Register copies of the fire masks, tying the LED to the documented bit positions.
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            fireSeenA_q <= '0;
            fireSeenB_q <= '0;
        end
        else
        begin
            fireSeenA_q <= regFire_q[FIRE_A_LSB +: 4];
            fireSeenB_q <= regFire_q[FIRE_B_LSB +: 4];
        end
    end

    a_fire_map_a: assert property (@(posedge mclk) disable iff (!rstSyncN)
        seqOut[0].ledOn |-> !fireSeenA_q[seqOut[0].pulsePos])
        else $error("Slot A fired a masked pulse.");
    a_fire_map_b: assert property (@(posedge mclk) disable iff (!rstSyncN)
        seqOut[1].ledOn |-> !fireSeenB_q[seqOut[1].pulsePos])
        else $error("Slot B fired a masked pulse.");
    a_reset_defaults: assert property (@(posedge mclk) disable iff (!rstSyncN)
        $rose(rstSyncN) |-> regEnA_q == RST_EN && regEnB_q == RST_EN && regFire_q == RST_FIRE)
        else $error("Registers did not come out of reset at their defaults.");
endmodule

// ### fmp_host_model.sv
// Serial host model that frames register reads and writes for the float-mode controller.
`timescale 1ns/1ps
module fmp_host_model
    import fmp_pkg::*;
(
    input  wire logic mclk,
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    // Each serial level stands five clocks, since the port filters its pins through a two-flop sync.
    task automatic hold();
        repeat (5) @(negedge mclk);
    endtask

    // One frame of address, write flag and data; read bits are taken just before each rise.
    task automatic xfer(input logic [ADDR_BITS-1:0] addr, input logic wr, input logic [DATA_BITS-1:0] wdata,
                        output logic [DATA_BITS-1:0] rdata);
        logic [23:0] frame;
        frame = {addr, wr, wdata};
        rdata = 16'h0000;
        csN = 1'b0;
        hold();
        for (int i = 23; i >= 0; i--)
        begin
            mosi = frame[i];
            hold();
            if (i < 16)
            begin
                rdata[i] = miso;
            end
            sclk = 1'b1;
            hold();
            sclk = 1'b0;
        end
        hold();
        csN = 1'b1;
        // A released data line must not keep its last value, so the host flips it between frames.
        mosi = ~mosi;
        repeat (2) hold();
    endtask

    // The serial clock idles low and stands still outside frames.
    initial
    begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end
endmodule

// ### fmp_float_control_tb.sv
// Self-checking testbench for the float-mode register bank and slot sequencers.
`timescale 1ns/1ps
module fmp_float_control_tb
    import fmp_pkg::*;
;
    logic         mclk;
    logic         resetn;
    logic         spiSclk;
    logic         spiCsN;
    logic         spiMosi;
    logic         spiMiso;
    logic         spiMisoOe;
    logic [1:0]   slotStart;
    logic [7:0]   pulseCount [2];
    logic [4:0]   pulseWidth [2];
    fmp_seq_out_t seqOut [2];
    logic [15:0]  rd;
    int           badCount;
    int           samplesChecked;
    logic [6:0]   addrs [5] = '{7'h58, 7'h59, 7'h5a, 7'h5e, 7'h00};
    logic [15:0]  rsts [5]  = '{16'h0000, 16'h0808, 16'h0010, 16'h0808, 16'h0000};
    logic [15:0]  vals [5]  = '{16'h0b24, 16'h7f08, 16'ha510, 16'h6308, 16'h1234};

    fmp_float_control i_dut (.mclk(mclk), .resetn(resetn), .spiSclk(spiSclk), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .slotStart(slotStart),
        .pulseCount(pulseCount), .pulseWidth(pulseWidth), .seqOut(seqOut));
    fmp_host_model i_host (.mclk(mclk), .sclk(spiSclk), .csN(spiCsN), .mosi(spiMosi), .miso(spiMiso));

    // The 50 MHz clock.
    always #10 mclk = ~mclk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finishTest();
        if (badCount == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Program a slot, run eight pulses and check each pulse's position, sign and firing.
    task automatic runSlot(input int s, input logic [3:0] mask, input logic [3:0] sg, input logic [4:0] pc);
        logic seen;
        int   n;
        int   k;
        i_host.xfer(s ? 7'h59 : 7'h5e, 1'b1, {3'b011, pc, 8'h08}, rd);
        i_host.xfer(7'h5a, 1'b1, s ? {mask, 4'h0, 8'h10} : {4'h0, mask, 8'h10}, rd);
        i_host.xfer(7'h58, 1'b1, s ? {4'h0, sg[1:0], 3'h0, sg[3:2], 5'h00} : {6'h00, sg[1:0], 5'h00, sg[3:2], 1'b0}, rd);
        slotStart[s] = 1'b1;
        n = 0;
        for (int p = 0; p < 8; p++)
        begin
            seen = 1'b0;
            k = 0;
            do
            begin
                @(negedge mclk);
                slotStart[s] = 1'b0;
                n++;
                k++;
                seen |= seqOut[s].ledOn;
            end
            while (seqOut[s].sampleStrobe !== 1'b1 && k < 4000);
            if (k >= 4000)
            begin
                badCount++;
                finishTest();
            end
            if (p == 0)
                check(16'(n), 16'(pc * 100 + 51));
            else
                check(16'(k), 16'h0064);
            check(16'(seqOut[s].pulsePos), 16'(p % 4));
            check(16'(seqOut[s].sampleSubtract), 16'(sg[3 - p % 4]));
            check(16'(seen), 16'(!mask[p % 4]));
        end
        // Busy stands through the whole gap after the last strobe and drops as it ends.
        repeat (49) @(negedge mclk);
        check(16'(seqOut[s].busy), 16'h0001);
        @(negedge mclk);
        check(16'(seqOut[s].busy), 16'h0000);
    endtask

    // Main sequence: reset, register map, refused starts, then full sequences.
    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        slotStart = 2'b00;
        pulseCount[0] = 8'h08;
        pulseCount[1] = 8'h08;
        pulseWidth[0] = 5'h01;
        pulseWidth[1] = 5'h01;
        badCount = 0;
        samplesChecked = 0;
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        for (int i = 0; i < 5; i++)
        begin
            i_host.xfer(addrs[i], 1'b0, 16'h0000, rd);
            check(rd, rsts[i]);
            i_host.xfer(addrs[i], 1'b1, vals[i], rd);
            fork
                i_host.xfer(addrs[i], 1'b0, 16'h0000, rd);
                begin
                    repeat (150) @(negedge mclk);
                    check(16'(spiMisoOe), 16'h0001);
                end
            join
            check(16'(spiMisoOe), 16'h0000);
            check(rd, i == 4 ? 16'h0000 : vals[i]);
        end
        // Codes 0, 1 and 2 must leave both slots idle.
        for (int c = 0; c < 6; c++)
        begin
            i_host.xfer(c[0] ? 7'h59 : 7'h5e, 1'b1, {1'b0, 2'(c / 2), 5'h01, 8'h08}, rd);
            slotStart[c[0]] = 1'b1;
            @(negedge mclk);
            slotStart[c[0]] = 1'b0;
            repeat (20) @(negedge mclk);
            check(16'(seqOut[c[0]].busy), 16'h0000);
        end
        for (int c = 0; c < 4; c++)
            runSlot(0, 4'(c * 5), {c[1:0], ~c[1:0]}, 5'(c * 7 + 1));
        runSlot(1, 4'b0110, 4'b1001, 5'h08);
        // Clearing slot A's enable during its long preconditioning delay must end the sequence.
        slotStart[0] = 1'b1;
        @(negedge mclk);
        slotStart[0] = 1'b0;
        check(16'(seqOut[0].busy), 16'h0001);
        i_host.xfer(7'h5e, 1'b1, 16'h1608, rd);
        check(16'(seqOut[0].busy), 16'h0000);
        finishTest();
    end
endmodule
